// ===== include/gpt_regs.svh
`ifndef GPT_REGS_SVH
`define GPT_REGS_SVH
// timer slots: aux and core of the first module, then the second module
`define GPT_NTMR 5
`define GPT_I_A1 0
`define GPT_I_C1 1
`define GPT_I_A2 2
`define GPT_I_A5 3
`define GPT_I_C6 4
// word indices, byte address is four times the index
`define GPT_ADR_CTL 4'h0
`define GPT_ADR_CNT 4'h5
`define GPT_ADR_CAP 4'hA
`define GPT_ADR_STS 4'hB
`define GPT_ADR_MSK 4'hC
`define GPT_ADR_PIN 4'hD
// timer control word fields
`define GPT_F_SEL 2:0
`define GPT_B_ER 0
`define GPT_B_EF 1
`define GPT_B_ET 2
`define GPT_F_MOD 5:3
`define GPT_B_RUN 6
`define GPT_B_DN 7
`define GPT_B_EXD 8
`define GPT_B_OE 9
`define GPT_B_AUX 10
`define GPT_F_CSRC 12:11
`define GPT_F_CEDG 14:13
`define GPT_B_CR 13
`define GPT_B_CF 14
// status layout
`define GPT_F_TEV 4:0
`define GPT_B_CEV 5
// prescaler
`define GPT_PRE1_BASE 4'h3
`define GPT_PRE2_BASE 4'h2
`define GPT_PRE_ALL 10'h3FF
`define GPT_CNT_MAX 16'hFFFF
`define GPT_CNT_MIN 16'h0000
`endif

// ===== include/gpt_pkg.sv
package gpt_pkg;
    // operating modes of one timer
    typedef enum logic [2:0] {
        GPT_M_TMR = 3'h0,
        GPT_M_CNT = 3'h1,
        GPT_M_GLO = 3'h2,
        GPT_M_GHI = 3'h3,
        GPT_M_RLD = 3'h4,
        GPT_M_CAP = 3'h5,
        GPT_M_ENC = 3'h6
    } gpt_mode_t;
    // capture source select
    typedef enum logic [1:0] {
        GPT_C_PIN = 2'h0,
        GPT_C_TIN = 2'h1,
        GPT_C_EUD = 2'h2,
        GPT_C_BOTH = 2'h3
    } gpt_csrc_t;
    // pin sample group
    typedef struct packed {
        logic capture_input_pin;
        logic [4:0] eud;
        logic [4:0] tin;
    } gpt_pins_t;
    // whole block state
    typedef struct packed {
        logic [9:0] pre;
        logic [4:0][15:0] ctl;
        logic [4:0][15:0] cnt;
        logic [15:0] capture_reload_reg;
        logic [5:0] sts;
        logic [5:0] msk;
        logic [1:0] otl;
        logic [1:0] otl_d;
        gpt_pins_t s1;
        gpt_pins_t s2;
        gpt_pins_t s3;
        logic ack;
        logic [31:0] dat;
        logic irq;
        logic out3;
        logic out6;
        logic ovf6;
    } gpt_state_t;
endpackage

// ===== core/gpt_top.sv
// Summary of operation
// - five 16-bit timers in two modules, free running or chained
// - first-module timers select timer, gated, counter or encoder mode
// - first-module prescaler divides clock by 8 doubling up to 1024
// - second-module prescaler divides clock by 4 doubling up to 512
// - counter mode advances on edges of the timer input pin
// - gated mode counts prescaled ticks only while gate level is active
// - encoder mode derives count and direction from signals A and B
// - first core toggle latch flips on wrap, drives pin or aux clocks
// - first-module aux timers act as reload or capture for core
// - second module: two timers, capture/reload, prescaled or pin clock
// - direction from software bit, optionally flipped by direction pin
// - second core toggle latch flips on wrap, clocks aux or drives pin
// - second core wrap clocks compare-unit timers, may reload from capture
// - capture pin edge latches second aux timer, optional clear after
// - capture also triggerable by first core input or direction pin
`timescale 1ns/1ps
`default_nettype none
`include "gpt_regs.svh"

module gpt_top (
    input wire logic MCLK_I,
    input wire logic RST_N_I,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [5:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    input wire logic [4:0] TIMER_INPUT_PIN_I,
    input wire logic [4:0] DIRECTION_INPUT_PIN_I,
    input wire logic CAPTURE_INPUT_PIN_I,
    output logic IRQ_O,
    output logic TOGGLE_OUTPUT_PIN_O,
    output logic SECOND_CORE_TOGGLE_PIN_O,
    output logic CC_TIMER_CLK_O
);
    gpt_pkg::gpt_state_t st_r;
    gpt_pkg::gpt_state_t st_nxt;
    gpt_pkg::gpt_pins_t pins;
    gpt_pkg::gpt_pins_t rise;
    gpt_pkg::gpt_pins_t fall;
    gpt_pkg::gpt_mode_t m;
    logic [4:0] inc;
    logic [4:0] dn;
    logic [4:0] ev;
    logic [4:0] edg;
    logic [15:0] c;
    logic [3:0] k;
    logic [9:0] pm;
    logic tick;
    logic tg;
    logic stp;
    logic cap;
    logic cpin;
    logic acc;
    logic wr;
    logic [3:0] idx;
    logic [2:0] ti;
    logic [15:0] wm;
    logic [15:0] wd;
    logic [15:0] rd;
    logic [5:0] clr;

    // pin group and bus decode
    assign pins = {CAPTURE_INPUT_PIN_I, DIRECTION_INPUT_PIN_I,
                   TIMER_INPUT_PIN_I};
    assign acc = WB_CYC_I & WB_STB_I & ~st_r.ack;
    assign wr = acc & WB_WE_I;
    assign idx = WB_ADR_I[5:2];
    assign ti = 3'(idx - `GPT_ADR_CNT);
    assign wm = {{8{WB_SEL_I[1]}}, {8{WB_SEL_I[0]}}};
    assign wd = WB_DAT_I[15:0];

    // next state of the whole block
    always_comb begin
        st_nxt = st_r;
        inc = '0;
        dn = '0;
        ev = '0;
        edg = '0;
        c = '0;
        k = '0;
        pm = '0;
        tick = 1'b0;
        tg = 1'b0;
        stp = 1'b0;
        m = gpt_pkg::GPT_M_TMR;
        cap = 1'b0;
        cpin = 1'b0;
        rd = '0;
        clr = '0;
        // free running divider and pin synchronisers
        st_nxt.pre = st_r.pre + 10'h001;
        st_nxt.s1 = pins;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        st_nxt.otl_d = st_r.otl;
        rise = gpt_pkg::gpt_pins_t'(st_r.s2 & ~st_r.s3);
        fall = gpt_pkg::gpt_pins_t'(~st_r.s2 & st_r.s3);
        // one pass per timer: count enable, direction, wrap
        for (int i = 0; i < `GPT_NTMR; i++) begin
            c = st_r.ctl[i];
            m = gpt_pkg::gpt_mode_t'(c[`GPT_F_MOD]);
            if (i < `GPT_I_A5) begin
                k = `GPT_PRE1_BASE + {1'b0, c[`GPT_F_SEL]};
            end else begin
                k = `GPT_PRE2_BASE + {1'b0, c[`GPT_F_SEL]};
            end
            pm = ~(`GPT_PRE_ALL << k);
            tick = (st_r.pre & pm) == pm;
            edg[i] = (c[`GPT_B_ER] & rise.tin[i]) |
                     (c[`GPT_B_EF] & fall.tin[i]);
            // aux timers may count the core toggle latch
            if (i == `GPT_I_A5) begin
                tg = st_r.otl[1] ^ st_r.otl_d[1];
            end else if (i != `GPT_I_C1 && i != `GPT_I_C6) begin
                tg = st_r.otl[0] ^ st_r.otl_d[0];
            end else begin
                tg = 1'b0;
            end
            unique case (m)
                gpt_pkg::GPT_M_TMR: begin
                    stp = tick;
                end
                gpt_pkg::GPT_M_GLO: begin
                    stp = tick & ~st_r.s2.tin[i];
                end
                gpt_pkg::GPT_M_GHI: begin
                    stp = tick & st_r.s2.tin[i];
                end
                gpt_pkg::GPT_M_CNT: begin
                    stp = c[`GPT_B_ET] ? tg : edg[i];
                end
                gpt_pkg::GPT_M_ENC: begin
                    stp = (i < `GPT_I_A5) & (rise.tin[i] | fall.tin[i] |
                          rise.eud[i] | fall.eud[i]);
                end
                gpt_pkg::GPT_M_RLD,
                gpt_pkg::GPT_M_CAP: begin
                    stp = 1'b0;
                end
                default: begin
                    stp = 1'b0;
                end
            endcase
            inc[i] = c[`GPT_B_RUN] & stp;
            if (m == gpt_pkg::GPT_M_ENC) begin
                dn[i] = ~(st_r.s2.tin[i] ^ st_r.s3.eud[i]);
            end else begin
                dn[i] = c[`GPT_B_DN] ^
                        (c[`GPT_B_EXD] & st_r.s2.eud[i]);
            end
            if (inc[i]) begin
                if (dn[i]) begin
                    ev[i] = st_r.cnt[i] == `GPT_CNT_MIN;
                    st_nxt.cnt[i] = st_r.cnt[i] - 16'h0001;
                end else begin
                    ev[i] = st_r.cnt[i] == `GPT_CNT_MAX;
                    st_nxt.cnt[i] = st_r.cnt[i] + 16'h0001;
                end
            end
        end
        // aux timers reload the first core on wrap, or capture it
        if (ev[`GPT_I_C1]) begin
            if (st_r.ctl[`GPT_I_A1][`GPT_F_MOD] == gpt_pkg::GPT_M_RLD) begin
                st_nxt.cnt[`GPT_I_C1] = st_r.cnt[`GPT_I_A1];
            end else if (st_r.ctl[`GPT_I_A2][`GPT_F_MOD] ==
                         gpt_pkg::GPT_M_RLD) begin
                st_nxt.cnt[`GPT_I_C1] = st_r.cnt[`GPT_I_A2];
            end
        end
        if (st_r.ctl[`GPT_I_A1][`GPT_F_MOD] == gpt_pkg::GPT_M_CAP &&
            edg[`GPT_I_A1]) begin
            st_nxt.cnt[`GPT_I_A1] = st_r.cnt[`GPT_I_C1];
        end
        if (st_r.ctl[`GPT_I_A2][`GPT_F_MOD] == gpt_pkg::GPT_M_CAP &&
            edg[`GPT_I_A2]) begin
            st_nxt.cnt[`GPT_I_A2] = st_r.cnt[`GPT_I_C1];
        end
        // second core reload from the capture/reload register
        if (ev[`GPT_I_C6] && st_r.ctl[`GPT_I_C6][`GPT_B_AUX]) begin
            st_nxt.cnt[`GPT_I_C6] = st_r.capture_reload_reg;
        end
        // capture trigger selection
        cpin = (st_r.ctl[`GPT_I_A5][`GPT_B_CR] & rise.capture_input_pin) |
               (st_r.ctl[`GPT_I_A5][`GPT_B_CF] & fall.capture_input_pin);
        unique case (gpt_pkg::gpt_csrc_t'(st_r.ctl[`GPT_I_A5][`GPT_F_CSRC]))
            gpt_pkg::GPT_C_PIN: begin
                cap = cpin;
            end
            gpt_pkg::GPT_C_TIN: begin
                cap = rise.tin[`GPT_I_C1] | fall.tin[`GPT_I_C1];
            end
            gpt_pkg::GPT_C_EUD: begin
                cap = rise.eud[`GPT_I_C1] | fall.eud[`GPT_I_C1];
            end
            gpt_pkg::GPT_C_BOTH: begin
                cap = rise.tin[`GPT_I_C1] | fall.tin[`GPT_I_C1] |
                      rise.eud[`GPT_I_C1] | fall.eud[`GPT_I_C1];
            end
        endcase
        if (cap) begin
            st_nxt.capture_reload_reg = st_r.cnt[`GPT_I_A5];
            if (st_r.ctl[`GPT_I_A5][`GPT_B_AUX]) begin
                st_nxt.cnt[`GPT_I_A5] = `GPT_CNT_MIN;
            end
        end
        // toggle latches and their outputs
        st_nxt.otl[0] = st_r.otl[0] ^ ev[`GPT_I_C1];
        st_nxt.otl[1] = st_r.otl[1] ^ ev[`GPT_I_C6];
        st_nxt.out3 = st_nxt.otl[0] & st_r.ctl[`GPT_I_C1][`GPT_B_OE];
        st_nxt.out6 = st_nxt.otl[1] & st_r.ctl[`GPT_I_C6][`GPT_B_OE];
        st_nxt.ovf6 = ev[`GPT_I_C6];
        // register writes, software wins over counting
        if (wr) begin
            if (idx < `GPT_ADR_CNT) begin
                st_nxt.ctl[idx[2:0]] = (st_r.ctl[idx[2:0]] & ~wm) |
                                       (wd & wm);
            end else if (idx < `GPT_ADR_CAP) begin
                st_nxt.cnt[ti] = (st_nxt.cnt[ti] & ~wm) | (wd & wm);
            end else if (idx == `GPT_ADR_CAP) begin
                st_nxt.capture_reload_reg = (st_nxt.capture_reload_reg & ~wm) | (wd & wm);
            end else if (idx == `GPT_ADR_STS) begin
                clr = wd[5:0] & wm[5:0];
            end else if (idx == `GPT_ADR_MSK) begin
                st_nxt.msk = (st_r.msk & ~wm[5:0]) | (wd[5:0] & wm[5:0]);
            end
        end
        // sticky flags: a new event beats a clear
        st_nxt.sts = (st_r.sts & ~clr) | {cap, ev};
        st_nxt.irq = |(st_nxt.sts & st_nxt.msk);
        // read mux, unmapped words read zero
        if (idx < `GPT_ADR_CNT) begin
            rd = st_r.ctl[idx[2:0]];
        end else if (idx < `GPT_ADR_CAP) begin
            rd = st_r.cnt[ti];
        end else if (idx == `GPT_ADR_CAP) begin
            rd = st_r.capture_reload_reg;
        end else if (idx == `GPT_ADR_STS) begin
            rd = {10'h000, st_r.sts};
        end else if (idx == `GPT_ADR_MSK) begin
            rd = {10'h000, st_r.msk};
        end else if (idx == `GPT_ADR_PIN) begin
            rd = {3'h0, st_r.s2, st_r.otl};
        end
        st_nxt.ack = acc;
        if (acc && !WB_WE_I) begin
            st_nxt.dat = {16'h0000, rd};
        end
    end

    // state register, synchronous clear
    always_ff @(posedge MCLK_I) begin
        if (!RST_N_I) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // outputs straight from the state register
    assign WB_DAT_O = st_r.dat;
    assign WB_ACK_O = st_r.ack;
    assign IRQ_O = st_r.irq;
    assign TOGGLE_OUTPUT_PIN_O = st_r.out3;
    assign SECOND_CORE_TOGGLE_PIN_O = st_r.out6;
    assign CC_TIMER_CLK_O = st_r.ovf6;

    // checks on the running block
    default clocking cb @(posedge MCLK_I);
    endclocking
    default disable iff (!RST_N_I);

    a_core_toggle:
    assert property (ev[`GPT_I_C1] |=>
        st_r.otl[0] != $past(st_r.otl[0]))
        else $error("first core toggle latch missed a wrap");

    a_sec_toggle:
    assert property (ev[`GPT_I_C6] |=>
        st_r.otl[1] != $past(st_r.otl[1]))
        else $error("second core toggle latch missed a wrap");

    a_cap_latch:
    assert property ((cap && !(wr && idx == `GPT_ADR_CAP)) |=>
        st_r.capture_reload_reg == $past(st_r.cnt[`GPT_I_A5]))
        else $error("capture did not latch second aux timer");

    a_cap_clear:
    assert property ((cap && st_r.ctl[`GPT_I_A5][`GPT_B_AUX] &&
        !(wr && ti == `GPT_I_A5 && idx < `GPT_ADR_CAP)) |=>
        st_r.cnt[`GPT_I_A5] == `GPT_CNT_MIN)
        else $error("second aux timer not cleared after capture");

    a_flag_set:
    assert property (|ev |=>
        (st_r.sts[`GPT_F_TEV] & $past(ev)) == $past(ev))
        else $error("timer wrap flag not set");

    a_irq_level:
    assert property (IRQ_O == |(st_r.sts & st_r.msk))
        else $error("interrupt output disagrees with flags");

    a_div_first:
    assert property ((inc[`GPT_I_C1] &&
        st_r.ctl[`GPT_I_C1][`GPT_F_MOD] == gpt_pkg::GPT_M_TMR) |=>
        !inc[`GPT_I_C1] [*7])
        else $error("first module prescaler shorter than 8");

    a_div_second:
    assert property ((inc[`GPT_I_C6] &&
        st_r.ctl[`GPT_I_C6][`GPT_F_MOD] == gpt_pkg::GPT_M_TMR) |=>
        !inc[`GPT_I_C6] [*3])
        else $error("second module prescaler shorter than 4");

    a_gate_block:
    assert property ((st_r.ctl[`GPT_I_C1][`GPT_F_MOD] ==
        gpt_pkg::GPT_M_GHI && !st_r.s2.tin[`GPT_I_C1]) |->
        !inc[`GPT_I_C1])
        else $error("gated timer counted with gate inactive");

    a_ovf_out:
    assert property (##1 CC_TIMER_CLK_O == $past(ev[`GPT_I_C6]))
        else $error("compare clock pulse not tied to wrap");

    a_ack_once:
    assert property (WB_ACK_O |=> !WB_ACK_O)
        else $error("bus acknowledge held longer than one cycle");

    c_core_wrap: cover property (ev[`GPT_I_C1]);
    c_capture: cover property (cap ##1 IRQ_O);
    c_reload: cover property (ev[`GPT_I_C6] &&
        st_r.ctl[`GPT_I_C6][`GPT_B_AUX]);
endmodule
`default_nettype wire

// ===== tb/gpt_pin_model.sv
`timescale 1ns/1ps
`default_nettype none

module gpt_pin_model (
    input wire logic clk_i,
    output logic [4:0] tmr_pin_o,
    output logic [4:0] dir_pin_o,
    output logic cap_pin_o
);
    // pins idle low until a scenario moves them
    initial begin
        tmr_pin_o = 5'h00;
        dir_pin_o = 5'h00;
        cap_pin_o = 1'b0;
    end

    // one level change just after an edge, then a settle gap of whole cycles
    task automatic flip(input int kind, input int idx, input int gap);
        @(posedge clk_i);
        case (kind)
            0: tmr_pin_o[idx] <= ~tmr_pin_o[idx];
            1: dir_pin_o[idx] <= ~dir_pin_o[idx];
            default: cap_pin_o <= ~cap_pin_o;
        endcase
        repeat (gap) @(posedge clk_i);
    endtask
endmodule

`default_nettype wire

// ===== tb/test_general_purpose_timer_unit.sv
`timescale 1ns/1ps
`default_nettype none
`include "gpt_regs.svh"

module test_general_purpose_timer_unit;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [5:0] adr = 6'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] dat_w = 32'h00000000;
    logic [31:0] dat_r;
    logic ack;
    logic irq;
    logic tgl1;
    logic tgl2;
    logic cc_clk;
    logic [4:0] tmr_pin;
    logic [4:0] dir_pin;
    logic cap_pin;
    logic [15:0] rd;
    logic [15:0] a0;
    time t_take;
    int err_count = 0;
    int samples_checked = 0;
    int cycles = 0;
    int cc_seen = 0;

    always #5 mclk = ~mclk;

    gpt_top dut_u (.MCLK_I(mclk), .RST_N_I(rst_n), .WB_CYC_I(cyc),
        .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel),
        .WB_DAT_I(dat_w), .WB_DAT_O(dat_r), .WB_ACK_O(ack),
        .TIMER_INPUT_PIN_I(tmr_pin), .DIRECTION_INPUT_PIN_I(dir_pin),
        .CAPTURE_INPUT_PIN_I(cap_pin), .IRQ_O(irq),
        .TOGGLE_OUTPUT_PIN_O(tgl1), .SECOND_CORE_TOGGLE_PIN_O(tgl2),
        .CC_TIMER_CLK_O(cc_clk));

    gpt_pin_model pm_u (.clk_i(mclk), .tmr_pin_o(tmr_pin),
        .dir_pin_o(dir_pin), .cap_pin_o(cap_pin));

    // cycle ceiling and compare-unit clock pulse count
    always @(posedge mclk) begin
        cycles++;
        if (cc_clk === 1'b1)
            cc_seen++;
        if (cycles == 40000) begin
            err_count++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        $display("mismatches %0d, comparisons %0d", err_count,
                 samples_checked);
        if (err_count == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    // classic cycle, entered just after an edge; taken edge time kept
    task automatic wb(input logic [3:0] w, input logic wr,
                      input logic [15:0] d, input logic [3:0] s);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= wr;
        adr <= {w, 2'b00};
        sel <= s;
        dat_w <= {16'h0000, d};
        @(posedge mclk);
        t_take = $time;
        while (ack !== 1'b1 && n < 20) begin
            @(posedge mclk);
            n++;
        end
        rd = dat_r[15:0];
        if (n == 20) begin
            err_count++;
            give_verdict();
        end
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic wr(input logic [3:0] w, input logic [15:0] d);
        wb(w, 1'b1, d, 4'h3);
    endtask

    task automatic rdchk(input logic [3:0] w, input logic [15:0] exp);
        wb(w, 1'b0, 16'h0000, 4'h3);
        check(rd, exp);
    endtask

    function automatic logic [15:0] cw(input logic [2:0] s,
            input gpt_pkg::gpt_mode_t m, input logic [9:0] f);
        return {f, m, s};
    endfunction

    function automatic logic [3:0] cnt(input int i);
        return `GPT_ADR_CNT + 4'(i);
    endfunction

    // ticks over a window of exactly two prescaler periods
    task automatic rate(input int i, input logic [15:0] c, input int p,
                        input logic [15:0] exp);
        time t0;
        wr(4'(i), c);
        wb(cnt(i), 1'b0, 16'h0000, 4'h3);
        a0 = rd;
        t0 = t_take;
        while ($time < t0 + p * 20 - 10)
            @(posedge mclk);
        wb(cnt(i), 1'b0, 16'h0000, 4'h3);
        check(16'(rd - a0), exp);
    endtask

    task automatic wait_irq();
        int n;
        n = 0;
        while (irq !== 1'b1 && n < 2200) begin
            @(posedge mclk);
            n++;
        end
        // a wrap that never comes ends the run as a failure
        if (n == 2200) begin
            err_count++;
            give_verdict();
        end
    endtask

    task automatic sc_reset_map();
        for (int i = 0; i < 14; i++)
            rdchk(4'(i), 16'h0000);
        wr(4'hE, 16'hFFFF);
        rdchk(4'hE, 16'h0000);
        wb(4'h3, 1'b1, 16'hABCD, 4'h1);
        rdchk(4'h3, 16'h00CD);
        wr(4'h3, 16'h0000);
    endtask

    task automatic sc_prescale();
        for (int s = 0; s < 8; s++) begin
            rate(1, cw(3'(s), gpt_pkg::GPT_M_TMR, 10'h001), 8 << s,
                 16'h0002);
            rate(4, cw(3'(s), gpt_pkg::GPT_M_TMR, 10'h001), 4 << s,
                 16'h0002);
        end
        rate(1, cw(3'h0, gpt_pkg::GPT_M_TMR, 10'h003), 8, 16'hFFFE);
        rate(1, cw(3'h0, gpt_pkg::GPT_M_TMR, 10'h000), 8, 16'h0000);
    endtask

    task automatic sc_count_gate_enc();
        wr(cnt(0), 16'h0000);
        wr(4'h0, cw(3'h3, gpt_pkg::GPT_M_CNT, 10'h001));
        for (int k = 0; k < 6; k++)
            pm_u.flip(0, 0, 2 + k);
        rdchk(cnt(0), 16'h0006);
        pm_u.flip(1, 0, 2);
        wr(4'h0, cw(3'h3, gpt_pkg::GPT_M_CNT, 10'h005));
        pm_u.flip(0, 0, 2);
        pm_u.flip(0, 0, 5);
        rdchk(cnt(0), 16'h0004);
        rate(2, cw(3'h0, gpt_pkg::GPT_M_GHI, 10'h001), 8, 16'h0000);
        pm_u.flip(0, 2, 4);
        rate(2, cw(3'h0, gpt_pkg::GPT_M_GHI, 10'h001), 8, 16'h0002);
        rate(2, cw(3'h0, gpt_pkg::GPT_M_GLO, 10'h001), 8, 16'h0000);
        wr(cnt(1), 16'h0000);
        wr(4'h1, cw(3'h0, gpt_pkg::GPT_M_ENC, 10'h001));
        for (int k = 0; k < 4; k++)
            pm_u.flip(k % 2, 1, 3);
        rdchk(cnt(1), 16'h0004);
        for (int k = 0; k < 3; k++)
            pm_u.flip((k + 1) % 2, 1, 3);
        rdchk(cnt(1), 16'h0001);
    endtask

    task automatic sc_wrap();
        wr(4'h1, 16'h0000);
        wr(cnt(0), 16'h4321);
        wr(4'h0, cw(3'h0, gpt_pkg::GPT_M_RLD, 10'h000));
        // switch slot 2 to latch counting before clearing it
        wr(4'h2, cw(3'h4, gpt_pkg::GPT_M_CNT, 10'h001));
        wr(cnt(2), 16'h0000);
        wr(`GPT_ADR_STS, 16'h003F);
        wr(`GPT_ADR_MSK, 16'h0002);
        wr(cnt(1), 16'hFFFF);
        wr(4'h1, cw(3'h7, gpt_pkg::GPT_M_TMR, 10'h009));
        wait_irq();
        check({15'h0000, tgl1}, 16'h0001);
        rdchk(cnt(1), 16'h4321);
        rdchk(cnt(2), 16'h0001);
        wb(`GPT_ADR_STS, 1'b0, 16'h0000, 4'h3);
        check({15'h0000, rd[1]}, 16'h0001);
        wr(`GPT_ADR_MSK, 16'h0000);
        check({15'h0000, irq}, 16'h0000);
        wr(`GPT_ADR_MSK, 16'h0002);
        check({15'h0000, irq}, 16'h0001);
        wr(`GPT_ADR_STS, 16'h0002);
        check({15'h0000, irq}, 16'h0000);
        wr(`GPT_ADR_CAP, 16'h1234);
        wr(`GPT_ADR_MSK, 16'h0010);
        // stop the second core so no tick lands before reload is armed
        wr(4'h4, 16'h0000);
        wr(cnt(4), 16'hFFFF);
        cc_seen = 0;
        wr(4'h4, cw(3'h7, gpt_pkg::GPT_M_TMR, 10'h019));
        wait_irq();
        rdchk(cnt(4), 16'h1234);
        check({15'h0000, tgl2}, 16'h0001);
        check(16'(cc_seen), 16'h0001);
    endtask

    task automatic sc_capture();
        // aux slot 0 captures the stopped first core on its own pin edge
        wr(4'h1, 16'h0000);
        wr(cnt(1), 16'h0ABC);
        wr(4'h0, cw(3'h1, gpt_pkg::GPT_M_CAP, 10'h000));
        pm_u.flip(0, 0, 5);
        rdchk(cnt(0), 16'h0ABC);
        wr(cnt(3), 16'h0055);
        wr(4'h3, cw(3'h0, gpt_pkg::GPT_M_TMR, 10'h090));
        pm_u.flip(2, 0, 5);
        rdchk(`GPT_ADR_CAP, 16'h0055);
        rdchk(cnt(3), 16'h0000);
        wb(`GPT_ADR_STS, 1'b0, 16'h0000, 4'h3);
        check({15'h0000, rd[5]}, 16'h0001);
        wr(cnt(3), 16'h0077);
        wr(4'h3, cw(3'h0, gpt_pkg::GPT_M_TMR, 10'h020));
        pm_u.flip(0, 1, 5);
        rdchk(`GPT_ADR_CAP, 16'h0077);
        rdchk(cnt(3), 16'h0077);
        wr(cnt(3), 16'h0099);
        wr(4'h3, cw(3'h0, gpt_pkg::GPT_M_TMR, 10'h040));
        pm_u.flip(1, 1, 5);
        rdchk(`GPT_ADR_CAP, 16'h0099);
        wr(cnt(3), 16'h00AA);
        wr(4'h3, cw(3'h0, gpt_pkg::GPT_M_TMR, 10'h060));
        pm_u.flip(0, 1, 5);
        rdchk(`GPT_ADR_CAP, 16'h00AA);
    endtask

    // reset for three cycles, then the scenarios in turn
    initial begin
        repeat (3) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        sc_reset_map();
        sc_prescale();
        sc_count_gate_enc();
        sc_wrap();
        sc_capture();
        give_verdict();
    end
endmodule

`default_nettype wire
